//--- logic/gls_map.vh
// register map, field positions, reset values and timing defaults of the load scheduler
// assumes a 32-bit apb slave with word-aligned byte addresses
`ifndef GLS_MAP_VH
`define GLS_MAP_VH
`define GLS_OFF_CTRL 6'h00
`define GLS_OFF_THR 6'h04
`define GLS_OFF_DLY_ACT 6'h08
`define GLS_OFF_DLY_DEACT 6'h0c
`define GLS_OFF_DLY_INIT 6'h10
`define GLS_OFF_MIN 6'h14
`define GLS_OFF_LEADER 6'h18
`define GLS_OFF_EXCL 6'h1c
`define GLS_OFF_EVT_MASK 6'h20
`define GLS_OFF_ROT_TIME 6'h24
`define GLS_OFF_ROT_HOURS 6'h28
`define GLS_OFF_STATUS 6'h2c
`define GLS_OFF_SUM_ACT 6'h30
`define GLS_OFF_SUM_NOM 6'h34
// ctrl fields
`define GLS_CTRL_OPM_LSB 0
`define GLS_CTRL_ROT_LSB 2
`define GLS_CTRL_EN_ASSIGNED 4
`define GLS_CTRL_GB_PRESENT 5
`define GLS_CTRL_AUTO_REQ 6
// operating modes
`define GLS_OPM_MAN 2'h0
`define GLS_OPM_AUTO 2'h1
`define GLS_OPM_REMOTE 2'h2
`define GLS_OPM_TEST 2'h3
// rotation modes
`define GLS_ROT_MANUAL 2'h1
`define GLS_ROT_DAILY 2'h2
`define GLS_ROT_HOURS 2'h3
// event mask bit for leader change
`define GLS_EVT_LEADER_BIT 8
// reset values
`define GLS_RST_CTRL 7'h05
`define GLS_RST_THR_ACT 8'h50
`define GLS_RST_THR_DEACT 8'h46
`define GLS_RST_DLY_ACT 16'h000a
`define GLS_RST_DLY_DEACT 16'h001e
`define GLS_RST_DLY_INIT 16'h0005
`define GLS_RST_MIN 4'h1
`define GLS_RST_ROT_TIME 11'h000
`define GLS_RST_ROT_HOURS 16'h0018
// percent scale of the ratio comparisons
`define GLS_PCT 32'h00000064
`endif

//--- logic/gls_sched.v
// generator set load scheduler: starts and stops managed sets from the system power ratio
// assumes i_tick is a one-cycle control tick, power words come from can logic on i_clk_sys,
// breaker, enable and local start pins are asynchronous; apb master on i_clk_sys
//
// Notes on behaviour
// - load decisions only in automatic or remote-start mode; otherwise commands freeze
// - assigned enable input inactive suspends scheduling
// - group breaker present and open disables scheduling
// - ratio is active sum over nominal sum of all closed-breaker sets
// - ratio above activation threshold for activation delay starts one more set
// - stop candidate chosen; ratio without its nominal below deactivation threshold stops it
// - no stop while started sets at or below minimum; starts to reach it
// - any generator breaker change suspends evaluation for initial delay
// - automatic supply needed while all stopped starts all available sets
// - local start forces all available sets, then normal scheduling resumes
// - unmanaged sets excluded; excluded managed sets held stopped or running
// - exclusion list is volatile and cleared at reset
// - all scheduled sets may stop when enough unmanaged sets run
// - start in descending priority, stop ascending; top included set leads
// - rotation mode 1 manual, 2 daily, 3 running hours
// - priority list runs by address from leader, wrapping below it
// - daily mode advances leader at configured time; manual choice still allowed
// - hours mode advances leader after configured running hours
// - after leader change start higher sets first, then stop lower ones
// - leader change event only when mask bit enabled
`timescale 1ns/1ps
`include "gls_map.vh"
module gls_sched #(
  parameter NSET = 8,
  parameter IDXW = 3,
  parameter PWRW = 16
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_tick,
  input wire i_hour_tick,
  input wire [10:0] i_time_of_day,
  input wire [NSET*PWRW-1:0] i_set_active_power,
  input wire [NSET*PWRW-1:0] i_set_nominal_power,
  input wire [NSET-1:0] i_set_managed,
  input wire [NSET-1:0] i_generator_breaker,
  input wire i_group_breaker,
  input wire i_load_sched_enable_input,
  input wire i_local_start,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [5:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  output reg [NSET-1:0] o_start_cmd,
  output reg o_leader_change_event
);
  localparam NPIN = NSET + 3;
  localparam [IDXW:0] NCNT = NSET;

  // position of set idx in the list that starts at the leader
  function [IDXW:0] rank_of;
    input [IDXW-1:0] idx;
    input [IDXW-1:0] lead;
    input [NSET-1:0] incl;
    reg [IDXW-1:0] pj;
    reg [IDXW-1:0] pi;
    integer j;
    begin
      rank_of = {(IDXW+1){1'b0}};
      pi = idx - lead;
      for (j = 0; j < NSET; j = j + 1) begin
        pj = j[IDXW-1:0] - lead;
        if (incl[j] && pj < pi)
          rank_of = rank_of + 1'b1;
      end
    end
  endfunction

  // next included set after the leader in address order, wrapping
  function [IDXW-1:0] next_leader;
    input [IDXW-1:0] lead;
    input [NSET-1:0] incl;
    integer k;
    reg found;
    reg [IDXW-1:0] c;
    begin
      next_leader = lead;
      found = 1'b0;
      for (k = 1; k < NSET; k = k + 1) begin
        c = lead + k[IDXW-1:0];
        if (!found && incl[c]) begin
          next_leader = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  function [IDXW:0] popcount;
    input [NSET-1:0] v;
    integer k;
    begin
      popcount = {(IDXW+1){1'b0}};
      for (k = 0; k < NSET; k = k + 1)
        popcount = popcount + {{IDXW{1'b0}}, v[k]};
    end
  endfunction

  // pin synchronisers: a change counts once stages two and three agree
  reg [NPIN-1:0] pin_s1_q;
  reg [NPIN-1:0] pin_s2_q;
  reg [NPIN-1:0] pin_s3_q;
  reg [NPIN-1:0] pin_q;
  wire [NPIN-1:0] pin_raw = {i_local_start, i_load_sched_enable_input, i_group_breaker, i_generator_breaker};
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      pin_s1_q <= {NPIN{1'b0}};
      pin_s2_q <= {NPIN{1'b0}};
      pin_s3_q <= {NPIN{1'b0}};
      pin_q <= {NPIN{1'b0}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
    end
  end
  wire [NSET-1:0] brk = pin_q[NSET-1:0];
  wire gb_closed = pin_q[NSET];
  wire en_pin = pin_q[NSET+1];
  wire loc_pin = pin_q[NSET+2];

  // software registers
  reg [6:0] ctrl_q;
  reg [7:0] thr_act_q;
  reg [7:0] thr_deact_q;
  reg [15:0] dly_act_q;
  reg [15:0] dly_deact_q;
  reg [15:0] dly_init_q;
  reg [15:0] rot_hours_q;
  reg [3:0] min_q;
  reg [NSET-1:0] excl_q;
  reg [NSET-1:0] force_run_q;
  reg [31:0] evt_mask_q;
  reg [10:0] rot_time_q;
  reg [IDXW-1:0] leader_q;
  // scheduler state
  reg [IDXW:0] nrun_q;
  reg [15:0] act_cnt_q;
  reg [15:0] deact_cnt_q;
  reg [15:0] stab_cnt_q;
  reg [15:0] hour_cnt_q;
  reg [NSET-1:0] brk_prev_q;
  reg [NSET-1:0] old_cmd_q;
  reg loc_prev_q;
  reg hold_q;
  reg rebuild_q;
  reg [10:0] tod_prev_q;

  wire [1:0] opm = ctrl_q[`GLS_CTRL_OPM_LSB+1:`GLS_CTRL_OPM_LSB];
  wire [1:0] rot = ctrl_q[`GLS_CTRL_ROT_LSB+1:`GLS_CTRL_ROT_LSB];
  wire auto_mode = (opm == `GLS_OPM_AUTO) || (opm == `GLS_OPM_REMOTE);
  wire sched_en = auto_mode && !hold_q && (!ctrl_q[`GLS_CTRL_EN_ASSIGNED] || en_pin) &&
    !(ctrl_q[`GLS_CTRL_GB_PRESENT] && !gb_closed);
  // unmanaged and excluded sets kept out
  wire [NSET-1:0] incl = i_set_managed & ~excl_q;
  wire [IDXW:0] incl_cnt = popcount(incl);
  wire [IDXW:0] started_cnt = popcount(brk);

  // sums over closed breakers, desired mask and stop candidate
  reg [31:0] sum_act;
  reg [31:0] sum_nom;
  reg [31:0] nom_cand;
  reg [NSET-1:0] desired;
  integer i;
  always @* begin
    sum_act = 32'h0;
    sum_nom = 32'h0;
    nom_cand = 32'h0;
    desired = {NSET{1'b0}};
    for (i = 0; i < NSET; i = i + 1) begin
      if (brk[i]) begin
        sum_act = sum_act + {{(32-PWRW){1'b0}}, i_set_active_power[i*PWRW +: PWRW]};
        sum_nom = sum_nom + {{(32-PWRW){1'b0}}, i_set_nominal_power[i*PWRW +: PWRW]};
      end
      if (incl[i] && rank_of(i[IDXW-1:0], leader_q, incl) < nrun_q)
        desired[i] = 1'b1;
      // stop candidate: the lowest-ranked running set inside the target count
      if (incl[i] && brk[i] && nrun_q != {(IDXW+1){1'b0}} &&
          rank_of(i[IDXW-1:0], leader_q, incl) == nrun_q - 1'b1)
        nom_cand = {{(32-PWRW){1'b0}}, i_set_nominal_power[i*PWRW +: PWRW]};
    end
  end

  // ratio valid only with nonzero nominal sum
  wire ratio_ok = (sum_nom != 32'h0);
  // ratio above activation threshold, compared without division
  wire over = (sum_act * `GLS_PCT) > ({24'h0, thr_act_q} * sum_nom);
  // ratio without candidate below deactivation threshold
  wire under_n = (nom_cand != 32'h0) && (sum_nom > nom_cand) &&
    ((sum_act * `GLS_PCT) < ({24'h0, thr_deact_q} * (sum_nom - nom_cand)));
  wire all_up = ((desired & ~brk) == {NSET{1'b0}});
  // stabilisation window after any generator breaker change
  wire brk_change = (brk != brk_prev_q);
  wire evaluate = sched_en && ratio_ok && (stab_cnt_q == 16'h0) && !brk_change;
  // stop allowed only above the minimum of started sets
  wire stop_ok = ({{(4-IDXW-1){1'b0}}, started_cnt} > min_q) || (IDXW + 1 > 4 && started_cnt > NCNT);
  wire loc_edge = loc_pin && !loc_prev_q;

  // leader change sources
  // a write lands at the edge that samples pready high
  wire apb_wr = i_psel && i_penable && o_pready && i_pwrite;
  wire wr_leader = apb_wr && (i_paddr == `GLS_OFF_LEADER);
  wire rot_day = (rot == `GLS_ROT_DAILY) && (i_time_of_day == rot_time_q) && (i_time_of_day != tod_prev_q);
  wire rot_hour = (rot == `GLS_ROT_HOURS) && i_hour_tick && brk[leader_q] &&
    (hour_cnt_q + 16'h1 >= rot_hours_q) && (rot_hours_q != 16'h0);
  wire [IDXW-1:0] lead_d = wr_leader ? i_pwdata[IDXW-1:0] :
    ((rot_day || rot_hour) ? next_leader(leader_q, incl) : leader_q);
  wire lead_chg = (lead_d != leader_q);

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      leader_q <= {IDXW{1'b0}};
      nrun_q <= {(IDXW+1){1'b0}};
      act_cnt_q <= 16'h0;
      deact_cnt_q <= 16'h0;
      stab_cnt_q <= 16'h0;
      hour_cnt_q <= 16'h0;
      brk_prev_q <= {NSET{1'b0}};
      old_cmd_q <= {NSET{1'b0}};
      loc_prev_q <= 1'b0;
      hold_q <= 1'b0;
      rebuild_q <= 1'b0;
      tod_prev_q <= 11'h0;
      o_start_cmd <= {NSET{1'b0}};
      o_leader_change_event <= 1'b0;
    end else begin
      brk_prev_q <= brk;
      loc_prev_q <= loc_pin;
      tod_prev_q <= i_time_of_day;
      leader_q <= lead_d;
      o_leader_change_event <= lead_chg && evt_mask_q[`GLS_EVT_LEADER_BIT];
      if (rot_hour || (rot != `GLS_ROT_HOURS))
        hour_cnt_q <= 16'h0;
      else if (i_hour_tick && brk[leader_q])
        hour_cnt_q <= hour_cnt_q + 16'h1;
      // keep old sets until the new list is supplying
      if (lead_chg) begin
        rebuild_q <= 1'b1;
        old_cmd_q <= o_start_cmd;
      end else if (rebuild_q && all_up)
        rebuild_q <= 1'b0;
      if (brk_change)
        stab_cnt_q <= dly_init_q;
      else if (i_tick && stab_cnt_q != 16'h0)
        stab_cnt_q <= stab_cnt_q - 16'h1;
      // local start forces all, releases once supplying
      if (auto_mode && loc_edge) begin
        hold_q <= 1'b1;
        nrun_q <= incl_cnt;
      end else if (hold_q && (all_up || !auto_mode))
        hold_q <= 1'b0;
      else if (sched_en && ctrl_q[`GLS_CTRL_AUTO_REQ] && started_cnt == {(IDXW+1){1'b0}})
        nrun_q <= incl_cnt;
      else if (nrun_q > incl_cnt)
        nrun_q <= incl_cnt;
      else if (evaluate && i_tick) begin
        if ({{(4-IDXW-1){1'b0}}, started_cnt} < min_q && nrun_q < incl_cnt && all_up)
          nrun_q <= nrun_q + 1'b1;
        // one more set after the activation delay
        else if (over && act_cnt_q + 16'h1 >= dly_act_q && nrun_q < incl_cnt)
          nrun_q <= nrun_q + 1'b1;
        // stop the candidate after the deactivation delay
        else if (under_n && stop_ok && !rebuild_q && deact_cnt_q + 16'h1 >= dly_deact_q)
          nrun_q <= nrun_q - 1'b1;
      end
      if (!evaluate || !over)
        act_cnt_q <= 16'h0;
      else if (i_tick)
        act_cnt_q <= (act_cnt_q + 16'h1 >= dly_act_q) ? 16'h0 : act_cnt_q + 16'h1;
      if (!evaluate || !under_n || !stop_ok)
        deact_cnt_q <= 16'h0;
      else if (i_tick)
        deact_cnt_q <= (deact_cnt_q + 16'h1 >= dly_deact_q) ? 16'h0 : deact_cnt_q + 16'h1;
      // commands update only in auto modes, frozen otherwise
      if (auto_mode)
        // excluded sets forced stopped or running
        o_start_cmd <= ((desired | (rebuild_q ? old_cmd_q : {NSET{1'b0}})) & incl) |
          (i_set_managed & excl_q & force_run_q);
    end
  end

  // apb slave: one wait state, registered answer
  wire apb_acc = i_psel && i_penable && !o_pready;
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_q <= `GLS_RST_CTRL;
      thr_act_q <= `GLS_RST_THR_ACT;
      thr_deact_q <= `GLS_RST_THR_DEACT;
      dly_act_q <= `GLS_RST_DLY_ACT;
      dly_deact_q <= `GLS_RST_DLY_DEACT;
      dly_init_q <= `GLS_RST_DLY_INIT;
      min_q <= `GLS_RST_MIN;
      excl_q <= {NSET{1'b0}};
      force_run_q <= {NSET{1'b0}};
      evt_mask_q <= 32'h0;
      rot_time_q <= `GLS_RST_ROT_TIME;
      rot_hours_q <= `GLS_RST_ROT_HOURS;
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_acc;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
      if (apb_wr) begin
        case (i_paddr)
          `GLS_OFF_CTRL: ctrl_q <= i_pwdata[6:0];
          `GLS_OFF_THR: begin
            thr_act_q <= i_pwdata[7:0];
            thr_deact_q <= i_pwdata[15:8];
          end
          `GLS_OFF_DLY_ACT: dly_act_q <= i_pwdata[15:0];
          `GLS_OFF_DLY_DEACT: dly_deact_q <= i_pwdata[15:0];
          `GLS_OFF_DLY_INIT: dly_init_q <= i_pwdata[15:0];
          `GLS_OFF_MIN: min_q <= (i_pwdata[3:0] == 4'h0) ? 4'h1 : i_pwdata[3:0];
          `GLS_OFF_EXCL: begin
            excl_q <= i_pwdata[NSET-1:0];
            force_run_q <= i_pwdata[NSET+7:8];
          end
          `GLS_OFF_EVT_MASK: evt_mask_q <= i_pwdata;
          `GLS_OFF_ROT_TIME: rot_time_q <= i_pwdata[10:0];
          `GLS_OFF_ROT_HOURS: rot_hours_q <= i_pwdata[15:0];
          default: ;
        endcase
      end
      if (apb_acc) begin
        case (i_paddr)
          `GLS_OFF_CTRL: o_prdata <= {25'h0, ctrl_q};
          `GLS_OFF_THR: o_prdata <= {16'h0, thr_deact_q, thr_act_q};
          `GLS_OFF_DLY_ACT: o_prdata <= {16'h0, dly_act_q};
          `GLS_OFF_DLY_DEACT: o_prdata <= {16'h0, dly_deact_q};
          `GLS_OFF_DLY_INIT: o_prdata <= {16'h0, dly_init_q};
          `GLS_OFF_MIN: o_prdata <= {28'h0, min_q};
          `GLS_OFF_LEADER: o_prdata <= {{(32-IDXW){1'b0}}, leader_q};
          `GLS_OFF_EXCL: o_prdata <= {{(24-NSET){1'b0}}, force_run_q, {(8-NSET){1'b0}}, excl_q};
          `GLS_OFF_EVT_MASK: o_prdata <= evt_mask_q;
          `GLS_OFF_ROT_TIME: o_prdata <= {21'h0, rot_time_q};
          `GLS_OFF_ROT_HOURS: o_prdata <= {16'h0, rot_hours_q};
          // [15:12] target count, [11:8] flags, [7:0] run commands
          `GLS_OFF_STATUS: o_prdata <= {{(19-IDXW){1'b0}}, nrun_q, rebuild_q, hold_q,
            (stab_cnt_q != 16'h0), sched_en, {(8-NSET){1'b0}}, o_start_cmd};
          `GLS_OFF_SUM_ACT: o_prdata <= sum_act;
          `GLS_OFF_SUM_NOM: o_prdata <= sum_nom;
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

//--- tb/gls_sched_props.sv
// port checker for the load scheduler
// assumes apb writes land at the pready edge, as the scheduler's own registers do
`timescale 1ns/1ps
module gls_sched_props #(
  parameter NSET = 8
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [NSET-1:0] i_generator_breaker,
  input wire i_group_breaker,
  input wire i_load_sched_enable_input,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [5:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire [NSET-1:0] o_start_cmd,
  input wire o_leader_change_event
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  reg [6:0] ctrl_q;
  reg evt_en_q;
  reg [3:0] min_q;
  reg [3:0] frz_q;
  reg [3:0] off_q;
  wire wr = i_psel && i_penable && i_pwrite && o_pready;
  wire frz = ctrl_q[1:0] == 2'h0 || ctrl_q[1:0] == 2'h3;
  wire off = (ctrl_q[4] && !i_load_sched_enable_input) || (ctrl_q[5] && !i_group_breaker);
  // mirror of mode, minimum and event mask; the mask starts cleared
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_q <= 7'h05;
      evt_en_q <= 1'b0;
      min_q <= 4'h1;
    end else if (wr && i_paddr == 6'h00) begin
      ctrl_q <= i_pwdata[6:0];
    end else if (wr && i_paddr == 6'h14) begin
      min_q <= (i_pwdata[3:0] == 4'h0) ? 4'h1 : i_pwdata[3:0];
    end else if (wr && i_paddr == 6'h20) begin
      evt_en_q <= i_pwdata[8];
    end
  end
  // cycles spent in a state that must hold the commands
  always @(posedge i_clk_sys) begin
    frz_q <= (i_rst || !frz) ? 4'h0 : (frz_q == 4'hf ? frz_q : frz_q + 4'h1);
    off_q <= (i_rst || !off) ? 4'h0 : (off_q == 4'hf ? off_q : off_q + 4'h1);
  end
  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_stop;
    |($past(o_start_cmd) & ~o_start_cmd);
  endsequence
  property p_rst_quiet;
    disable iff (1'b0) i_rst |=> o_start_cmd == '0 && !o_pready && !o_leader_change_event;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy in reset");
  property p_pready_wait;
    s_access |=> o_pready;
  endproperty
  a_pready_wait: assert property (p_pready_wait) else $error("pready late");
  property p_pready_cause;
    o_pready |-> $past(i_psel && i_penable);
  endproperty
  a_pready_cause: assert property (p_pready_cause) else $error("pready without access");
  property p_err_ready;
    o_pslverr |-> o_pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_rdata_idle;
    !o_pready |-> o_prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  property p_evt_pulse;
    o_leader_change_event |=> !o_leader_change_event;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than a cycle");
  property p_evt_mask;
    o_leader_change_event |-> $past(evt_en_q);
  endproperty
  a_evt_mask: assert property (p_evt_mask) else $error("event while masked");
  property p_frozen;
    frz_q >= 4'h4 |-> $stable(o_start_cmd);
  endproperty
  a_frozen: assert property (p_frozen) else $error("commands moved in manual or test");
  property p_off;
    off_q >= 4'h8 |-> $stable(o_start_cmd);
  endproperty
  a_off: assert property (p_off) else $error("commands moved while disabled");
  property p_min;
    s_stop |-> $countones(i_generator_breaker) > min_q;
  endproperty
  a_min: assert property (p_min) else $error("stop at or below minimum");
endmodule
bind gls_sched gls_sched_props #(.NSET(NSET)) gls_sched_props_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_generator_breaker(i_generator_breaker), .i_group_breaker(i_group_breaker),
  .i_load_sched_enable_input(i_load_sched_enable_input), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .o_start_cmd(o_start_cmd), .o_leader_change_event(o_leader_change_event));

//--- tb/gls_genset_farm.sv
// genset controllers: breakers follow the run commands after a lag, power words report load
// assumes all sets have equal nominal power and share the load evenly
`timescale 1ns/1ps
module gls_genset_farm #(
  parameter NSET = 8,
  parameter LAG = 6
) (
  input wire i_clk_sys,
  input wire [NSET-1:0] i_start_cmd,
  input wire [7:0] i_load_pct,
  output reg [NSET-1:0] o_breaker = '0,
  output reg [NSET*16-1:0] o_active_power = '0,
  output reg [NSET*16-1:0] o_nominal_power = '0
);
  integer i;
  reg [7:0] age [0:NSET-1];
  reg flip = 1'b0;
  always @(posedge i_clk_sys) begin
    flip <= ~flip;
    for (i = 0; i < NSET; i = i + 1) begin
      if (o_breaker[i] == i_start_cmd[i] || age[i] === 8'hx) begin
        age[i] <= 8'h00;
      end else if (age[i] == LAG) begin
        o_breaker[i] <= i_start_cmd[i];
        age[i] <= 8'h00;
      end else begin
        age[i] <= age[i] + 8'h01;
      end
      // closed sets report their share, open ones only noise
      o_active_power[i*16+:16] <= o_breaker[i] ? {8'h00, i_load_pct} : {16{flip}};
      o_nominal_power[i*16+:16] <= o_breaker[i] ? 16'h0064 : {16{~flip}};
    end
  end
endmodule

//--- tb/tb_gls_sched.sv
// self-checking bench for the load scheduler with the genset farm on the far side
// assumes a control tick every 8 cycles and short delays written over apb
`timescale 1ns/1ps
module tb_gls_sched;
  reg i_clk_sys = 1'b0;
  reg i_rst = 1'b1;
  reg i_tick = 1'b0;
  reg i_hour_tick = 1'b0;
  reg [10:0] i_time_of_day = 11'h000;
  reg [7:0] i_set_managed = 8'h0f;
  reg i_group_breaker = 1'b1;
  reg i_load_sched_enable_input = 1'b0;
  reg i_local_start = 1'b0;
  reg i_psel = 1'b0;
  reg i_penable = 1'b0;
  reg i_pwrite = 1'b0;
  reg [5:0] i_paddr = 6'h00;
  reg [31:0] i_pwdata = 32'h0;
  reg [7:0] load = 8'h1e;
  wire o_pready;
  wire [31:0] o_prdata;
  wire o_pslverr;
  wire [7:0] o_start_cmd;
  wire o_leader_change_event;
  wire [7:0] i_generator_breaker;
  wire [127:0] i_set_active_power;
  wire [127:0] i_set_nominal_power;
  reg [31:0] rd;
  reg er;
  reg [2:0] tdiv = 3'h0;
  reg [38:0] rows [0:8];
  integer fails = 0;
  integer compares = 0;
  integer evts = 0;
  integer cyc = 0;
  integer k;
  gls_sched #(.NSET(8), .IDXW(3), .PWRW(16)) gls_sched_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_tick(i_tick), .i_hour_tick(i_hour_tick), .i_time_of_day(i_time_of_day),
    .i_set_active_power(i_set_active_power), .i_set_nominal_power(i_set_nominal_power),
    .i_set_managed(i_set_managed), .i_generator_breaker(i_generator_breaker),
    .i_group_breaker(i_group_breaker), .i_load_sched_enable_input(i_load_sched_enable_input),
    .i_local_start(i_local_start), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_start_cmd(o_start_cmd), .o_leader_change_event(o_leader_change_event));
  gls_genset_farm #(.NSET(8), .LAG(6)) gls_genset_farm_inst (.i_clk_sys(i_clk_sys),
    .i_start_cmd(o_start_cmd), .i_load_pct(load), .o_breaker(i_generator_breaker),
    .o_active_power(i_set_active_power), .o_nominal_power(i_set_nominal_power));
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    tdiv <= tdiv + 3'h1;
    i_tick <= (tdiv == 3'h7);
    cyc <= cyc + 1;
    if (o_leader_change_event === 1'b1) evts <= evts + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task end_sim;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [8*12-1:0] name, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("unexpected %0s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task apb(input [5:0] a, input w, input [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_paddr <= a;
      i_pwrite <= w;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      @(posedge i_clk_sys);
      while (o_pready !== 1'b1) @(posedge i_clk_sys);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask
  task wait_cmd(input [7:0] e, input first);
    reg [7:0] s;
    integer n;
    begin
      s = o_start_cmd;
      n = 0;
      while ((first ? o_start_cmd === s : o_start_cmd !== e) && n < 3000) begin
        @(posedge i_clk_sys);
        n = n + 1;
      end
      chk("start_cmd", {24'h0, e}, {24'h0, o_start_cmd});
    end
  endtask
  task hold(input [7:0] e);
    begin
      repeat (300) @(posedge i_clk_sys);
      chk("held_cmd", {24'h0, e}, {24'h0, o_start_cmd});
    end
  endtask
  initial begin
    rows[0] = {6'h00, 32'h05, 1'h0};
    rows[1] = {6'h04, 32'h4650, 1'h0};
    rows[2] = {6'h08, 32'h0a, 1'h0};
    rows[3] = {6'h0c, 32'h1e, 1'h0};
    rows[4] = {6'h10, 32'h05, 1'h0};
    rows[5] = {6'h14, 32'h01, 1'h0};
    rows[6] = {6'h24, 32'h00, 1'h0};
    rows[7] = {6'h28, 32'h18, 1'h0};
    rows[8] = {6'h3c, 32'h00, 1'h1};
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (k = 0; k < 9; k = k + 1) begin
      apb(rows[k][38:33], 1'b0, 32'h0);
      chk("prdata", rows[k][32:1], rd);
      chk("pslverr", {31'h0, rows[k][0]}, {31'h0, er});
    end
    apb(6'h14, 1'b1, 32'h0);
    apb(6'h14, 1'b0, 32'h0);
    chk("min", 32'h1, rd);
    $display("test registers done");
    apb(6'h08, 1'b1, 32'h2);
    apb(6'h0c, 1'b1, 32'h2);
    apb(6'h10, 1'b1, 32'h1);
    apb(6'h20, 1'b1, 32'h100);
    apb(6'h00, 1'b1, 32'h45);
    wait_cmd(8'h0f, 1'b0);
    wait_cmd(8'h07, 1'b1);
    wait_cmd(8'h01, 1'b0);
    i_local_start <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    i_local_start <= 1'b0;
    wait_cmd(8'h0f, 1'b0);
    wait_cmd(8'h01, 1'b0);
    load <= 8'h5f;
    wait_cmd(8'h03, 1'b1);
    load <= 8'h4b;
    hold(8'h03);
    $display("test load steps done");
    apb(6'h18, 1'b1, 32'h2);
    wait_cmd(8'h0f, 1'b1);
    wait_cmd(8'h0c, 1'b0);
    chk("events", 32'h1, evts);
    apb(6'h20, 1'b1, 32'h0);
    apb(6'h28, 1'b1, 32'h2);
    apb(6'h00, 1'b1, 32'h4d);
    repeat (2) begin
      i_hour_tick <= 1'b1;
      @(posedge i_clk_sys);
      i_hour_tick <= 1'b0;
      @(posedge i_clk_sys);
    end
    wait_cmd(8'h0d, 1'b1);
    wait_cmd(8'h09, 1'b0);
    apb(6'h24, 1'b1, 32'h5);
    apb(6'h00, 1'b1, 32'h49);
    i_time_of_day <= 11'h005;
    wait_cmd(8'h0b, 1'b1);
    wait_cmd(8'h03, 1'b0);
    chk("events", 32'h1, evts);
    $display("test rotation done");
    apb(6'h00, 1'b1, 32'h44);
    load <= 8'h0a;
    hold(8'h03);
    apb(6'h00, 1'b1, 32'h75);
    hold(8'h03);
    i_load_sched_enable_input <= 1'b1;
    i_group_breaker <= 1'b0;
    hold(8'h03);
    i_group_breaker <= 1'b1;
    wait_cmd(8'h01, 1'b0);
    $display("test suspend done");
    apb(6'h1c, 1'b1, 32'h0202);
    wait_cmd(8'h03, 1'b0);
    wait_cmd(8'h02, 1'b0);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    apb(6'h1c, 1'b0, 32'h0);
    chk("excl", 32'h0, rd);
    chk("start_cmd", 32'h0, {24'h0, o_start_cmd});
    $display("test exclusion and reset done");
    end_sim;
  end
endmodule
